// ==== verilog/sbh_pkg.sv ====
package sbh_pkg;
    // ==========================================================
    // Timing
    // ==========================================================
    localparam int unsigned CORE_CLK_HZ = 25000000;
    localparam int unsigned CLK_PERIOD_NS = 1000000000 / CORE_CLK_HZ;
    localparam int unsigned SAMPLE_RATE_HZ = 3000;
    localparam int unsigned PROCESS_TIME_US = 20;
    localparam int unsigned FIRST_HOLD_SAMPLES = 16;
    // Reference load figure of the original firmware at a 48 MHz core.
    localparam int unsigned BUSY_LOAD_AT_48MHZ = 16801;
    // Least times round up to whole nanoseconds and whole cycles.
    localparam int unsigned SAMPLE_PERIOD_NS = (1000000000 + SAMPLE_RATE_HZ - 1) / SAMPLE_RATE_HZ;
    localparam int unsigned BUSY_TIME_NS = SAMPLE_PERIOD_NS + PROCESS_TIME_US * 1000;
    localparam int unsigned FIRST_TIME_NS = FIRST_HOLD_SAMPLES * SAMPLE_PERIOD_NS + PROCESS_TIME_US * 1000;
    localparam int unsigned BUSY_CYCLES_DEF = (BUSY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
    localparam int unsigned FIRST_CYCLES_DEF = (FIRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;

    // ==========================================================
    // Widths and words
    // ==========================================================
    localparam int unsigned TIMER_W = 18;
    localparam int unsigned WORD_W = 32;
    localparam int unsigned CNT_W = 5;
    localparam int unsigned CHANNELS = 4;
    localparam logic [WORD_W-1:0] DUMMY_WORD = 32'h8000_0000;
    localparam logic [5:0] CMD_CODE_TOP = 6'h28;
    localparam int unsigned CMD_CODE_MSB = 31;
    localparam int unsigned CMD_CODE_LSB = 26;
    localparam int unsigned CMD_CH_MSB = 25;
    localparam int unsigned CMD_CH_LSB = 24;
    localparam logic [CNT_W-1:0] LAST_BIT = 5'h1f;

    typedef logic [TIMER_W-1:0] sbh_timer_t;
    typedef enum logic [1:0] {SBH_HOLD, SBH_WAIT, SBH_RELOAD, SBH_LISTEN} sbh_state_e;
endpackage

// ==== verilog/sbh_link_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface sbh_link_if;
    logic en;
    logic [31:0] tx_word;
    logic [31:0] rx_word;
    logic done_tgl;
    modport core (output en, output tx_word, input rx_word, input done_tgl);
    modport link (input en, input tx_word, output rx_word, output done_tgl);
endinterface
`default_nettype wire

// ==== verilog/sbh_shifter.sv ====
`timescale 1ns/1ns
`default_nettype none
module sbh_shifter (
    input wire logic serial_shift_clock_in,
    input wire logic rst_in,
    input wire logic ss_n_in,
    input wire logic mosi_in,
    output logic miso_out,
    sbh_link_if.link lnk
);
    import sbh_pkg::*;

    // ==========================================================
    // Link reset, taken over on the shift clock
    // ==========================================================
    logic rst_s1_ff;
    logic rst_s2_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic [WORD_W-1:0] rx_sh_ff;
    logic [WORD_W-1:0] rx_word_ff;
    logic tgl_ff;
    logic miso_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic [WORD_W-1:0] nxt_rx_sh;
    logic [WORD_W-1:0] nxt_rx_word;
    logic nxt_tgl;
    logic nxt_miso;

    always_ff @(negedge serial_shift_clock_in) begin
        rst_s1_ff <= rst_in;
        rst_s2_ff <= rst_s1_ff;
    end

    // ==========================================================
    // Receive on the second (falling) edge
    // ==========================================================
    // En and the transmit word only change while busy keeps the host quiet.
    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_rx_sh = rx_sh_ff;
        nxt_rx_word = rx_word_ff;
        nxt_tgl = tgl_ff;
        if (rst_s2_ff) begin
            nxt_cnt = '0;
            nxt_rx_sh = '0;
            nxt_rx_word = '0;
            nxt_tgl = 1'b0;
        end else if (!lnk.en) begin
            nxt_cnt = '0;
        end else if (!ss_n_in) begin
            nxt_rx_sh = {rx_sh_ff[WORD_W-2:0], mosi_in};
            if (cnt_ff == LAST_BIT) begin
                nxt_cnt = '0;
                nxt_rx_word = nxt_rx_sh;
                nxt_tgl = ~tgl_ff;
            end else begin
                nxt_cnt = cnt_ff + 5'h01;
            end
        end
    end

    always_ff @(negedge serial_shift_clock_in) begin
        cnt_ff <= nxt_cnt;
        rx_sh_ff <= nxt_rx_sh;
        rx_word_ff <= nxt_rx_word;
        tgl_ff <= nxt_tgl;
    end

    // ==========================================================
    // Transmit on the first (rising) edge
    // ==========================================================
    always_comb begin
        nxt_miso = rst_s2_ff ? 1'b0 : lnk.tx_word[~cnt_ff];
    end

    always_ff @(posedge serial_shift_clock_in) begin
        miso_ff <= nxt_miso;
    end

    assign miso_out = miso_ff;
    assign lnk.rx_word = rx_word_ff;
    assign lnk.done_tgl = tgl_ff;
endmodule
`default_nettype wire

// ==== verilog/sbh_top.sv ====
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - busy high unless a result waits
// - busy lasts sample period plus processing
// - timer loaded, expires at zero
// - timer starts with busy at transfer end
// - expiry: enable, load, stop, clear, unbusy
// - command code A0..A3 selects channel
// - start-up holds busy for sixteen samples
// - first word read is dummy 0x80000000
// - full command: busy, store, disable slave
// - result out while command comes in
// - data sampled on second clock edge
// - one 32-bit word each way
module sbh_top #(
    parameter sbh_pkg::sbh_timer_t BUSY_CYCLES = sbh_pkg::TIMER_W'(sbh_pkg::BUSY_CYCLES_DEF),
    parameter sbh_pkg::sbh_timer_t FIRST_CYCLES = sbh_pkg::TIMER_W'(sbh_pkg::FIRST_CYCLES_DEF)
) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic serial_shift_clock_in,
    input wire logic ss_n_in,
    input wire logic mosi_in,
    input wire logic [3:0][31:0] results_in,
    output logic miso_out,
    output logic busy_out
);
    import sbh_pkg::*;

    sbh_link_if lnk ();

    sbh_shifter u_shifter (
        .serial_shift_clock_in(serial_shift_clock_in),
        .rst_in(rst_in),
        .ss_n_in(ss_n_in),
        .mosi_in(mosi_in),
        .miso_out(miso_out),
        .lnk(lnk)
    );

    // ==========================================================
    // Transfer-done crossing
    // ==========================================================
    logic tgl_s1_ff;
    logic tgl_s2_ff;
    logic tgl_s3_ff;
    logic done_evt;

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            tgl_s1_ff <= 1'b0;
            tgl_s2_ff <= 1'b0;
            tgl_s3_ff <= 1'b0;
        end else begin
            tgl_s1_ff <= lnk.done_tgl;
            tgl_s2_ff <= tgl_s1_ff;
            tgl_s3_ff <= tgl_s2_ff;
        end
    end

    assign done_evt = tgl_s2_ff ^ tgl_s3_ff;

    // ==========================================================
    // Busy sequencer
    // ==========================================================
    sbh_state_e state_ff;
    sbh_state_e nxt_state;
    sbh_timer_t timer_ff;
    sbh_timer_t nxt_timer;
    logic busy_ff;
    logic nxt_busy;
    logic en_ff;
    logic nxt_en;
    logic [WORD_W-1:0] cmd_ff;
    logic [WORD_W-1:0] nxt_cmd;
    logic [WORD_W-1:0] tx_ff;
    logic [WORD_W-1:0] nxt_tx;
    logic code_ok;
    logic [1:0] chan;
    logic [WORD_W-1:0] sel_word;

    assign code_ok = cmd_ff[CMD_CODE_MSB:CMD_CODE_LSB] == CMD_CODE_TOP;
    assign chan = cmd_ff[CMD_CH_MSB:CMD_CH_LSB];
    // The result travels as its upper and lower halfword taken together.
    assign sel_word = {results_in[chan][31:16], results_in[chan][15:0]};

    always_comb begin
        nxt_state = state_ff;
        nxt_timer = timer_ff;
        nxt_busy = busy_ff;
        nxt_en = en_ff;
        nxt_cmd = cmd_ff;
        nxt_tx = tx_ff;
        unique case (state_ff)
            SBH_HOLD: begin
                if (timer_ff == '0) begin
                    nxt_tx = DUMMY_WORD;
                    nxt_state = SBH_RELOAD;
                end else begin
                    nxt_timer = timer_ff - 1'b1;
                end
            end
            SBH_LISTEN: begin
                if (done_evt) begin
                    nxt_busy = 1'b1;
                    nxt_cmd = lnk.rx_word;
                    nxt_en = 1'b0;
                    nxt_timer = BUSY_CYCLES;
                    nxt_state = SBH_WAIT;
                end else begin
                    nxt_busy = 1'b0;
                end
            end
            SBH_WAIT: begin
                if (timer_ff == '0) begin
                    nxt_state = SBH_RELOAD;
                end else begin
                    nxt_timer = timer_ff - 1'b1;
                end
            end
            SBH_RELOAD: begin
                nxt_en = 1'b1;
                if (code_ok) begin
                    nxt_tx = sel_word;
                end
                nxt_timer = '0;
                nxt_state = SBH_LISTEN;
            end
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            state_ff <= SBH_HOLD;
            timer_ff <= FIRST_CYCLES;
            busy_ff <= 1'b1;
            en_ff <= 1'b0;
            cmd_ff <= '0;
            tx_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            timer_ff <= nxt_timer;
            busy_ff <= nxt_busy;
            en_ff <= nxt_en;
            cmd_ff <= nxt_cmd;
            tx_ff <= nxt_tx;
        end
    end

    assign busy_out = busy_ff;
    assign lnk.en = en_ff;
    assign lnk.tx_word = tx_ff;

    // ==========================================================
    // Checks
    // ==========================================================
    sbh_timer_t busy_len_ff;

    always_ff @(posedge core_clk_in) begin
        if (rst_in || !busy_ff) begin
            busy_len_ff <= '0;
        end else if (busy_len_ff != '1) begin
            busy_len_ff <= busy_len_ff + 1'b1;
        end
    end

    AST_DONE_BUSY: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (state_ff == SBH_LISTEN && done_evt) |=> (busy_ff && !en_ff && cmd_ff == $past(lnk.rx_word)))
        else $error("Completed command did not raise busy and disable the slave.");
    AST_TIMER_LOAD: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (state_ff == SBH_LISTEN && done_evt) |=> (timer_ff == BUSY_CYCLES && state_ff == SBH_WAIT))
        else $error("Busy timer not loaded at transfer end.");
    AST_EXPIRE: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (state_ff == SBH_WAIT && timer_ff == '0) |=> state_ff == SBH_RELOAD)
        else $error("Timer expiry did not start the reload.");
    AST_RELOAD_ORDER: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (state_ff == SBH_RELOAD) |=> (en_ff && busy_ff && timer_ff == '0) ##1 !busy_ff)
        else $error("Reload steps out of order.");
    AST_MIN_BUSY: assert property (@(posedge core_clk_in) disable iff (rst_in)
        $fell(busy_ff) |-> $past(busy_len_ff) >= BUSY_CYCLES)
        else $error("Busy interval shorter than required.");
    AST_STARTUP: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (state_ff == SBH_HOLD) |-> (busy_ff && !en_ff))
        else $error("Slave active during start-up hold.");
    AST_DUMMY: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (state_ff == SBH_HOLD && timer_ff == '0) |=> ##1 (tx_ff == DUMMY_WORD && en_ff))
        else $error("First word is not the dummy value.");
    AST_RESET: assert property (@(posedge core_clk_in) disable iff (rst_in)
        $fell(rst_in) |-> (state_ff == SBH_HOLD && busy_ff && !en_ff && timer_ff == FIRST_CYCLES))
        else $error("Reset did not enter the start-up hold.");
    AST_CHAN_LOAD: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (state_ff == SBH_RELOAD && code_ok) |=> tx_ff == $past(sel_word))
        else $error("Selected channel result not loaded.");
    AST_BAD_CODE: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (state_ff == SBH_RELOAD && !code_ok) |=> ($stable(tx_ff) ##1 !busy_ff))
        else $error("Unknown command changed the buffer or kept busy.");
    AST_BUSY_LEVEL: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (state_ff != SBH_LISTEN) |-> busy_ff)
        else $error("Busy low while no result is waiting.");
endmodule
`default_nettype wire

// ==== tb/sbh_host_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module sbh_host_model (
    output logic sclk_out,
    output logic ss_n_out,
    output logic mosi_out,
    input wire logic miso_in,
    output logic [31:0] rx_out,
    output logic rx_valid_out
);
    // ==========================================================
    // Idle levels
    // ==========================================================
    // The shift clock idles low and only flush pulses it between frames, where the device counts no edges.
    initial begin
        sclk_out = 1'b0;
        ss_n_out = 1'b1;
        mosi_out = 1'b0;
        rx_out = 32'h0;
        rx_valid_out = 1'b0;
    end

    // ==========================================================
    // Bit and frame tasks
    // ==========================================================
    task automatic pulse(input logic bit_in, output logic smp);
        sclk_out = 1'b1;
        mosi_out = bit_in;
        #8;
        smp = miso_in;
        sclk_out = 1'b0;
        #7;
    endtask

    task automatic flush();
        logic d;
        repeat (4) pulse(mosi_out, d);
    endtask

    // A released data line shows the inverse of its last bit, so a late sample cannot match by luck.
    task automatic xfer(input logic [31:0] cmd, input int piece, input bit chk);
        logic [31:0] rx;
        for (int i = 31; i >= 0; i--) begin
            if ((31 - i) % piece == 0) begin
                ss_n_out = 1'b0;
                #10;
            end
            pulse(cmd[i], rx[i]);
            if ((32 - i) % piece == 0) begin
                ss_n_out = 1'b1;
                mosi_out = ~mosi_out;
                #40;
            end
        end
        if (chk) begin
            rx_out = rx;
            rx_valid_out = 1'b1;
            #1;
            rx_valid_out = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import sbh_pkg::*;
    localparam sbh_timer_t BUSY_N = 18'h14;
    localparam sbh_timer_t FIRST_N = 18'h28;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0][31:0] results = '0;
    logic sclk;
    logic ss_n;
    logic mosi;
    logic miso;
    logic busy;
    logic [31:0] rx;
    logic rx_valid;
    int failures = 0;
    int tests_run = 0;
    logic [31:0] exp_q[$];

    always #20 clk = ~clk;

    sbh_top #(.BUSY_CYCLES(BUSY_N), .FIRST_CYCLES(FIRST_N)) sbh_top_i (.core_clk_in(clk), .rst_in(rst),
        .serial_shift_clock_in(sclk), .ss_n_in(ss_n), .mosi_in(mosi), .results_in(results),
        .miso_out(miso), .busy_out(busy));
    sbh_host_model sbh_host_model_i (.sclk_out(sclk), .ss_n_out(ss_n), .mosi_out(mosi), .miso_in(miso),
        .rx_out(rx), .rx_valid_out(rx_valid));

    // ==========================================================
    // Compare and report
    // ==========================================================
    task automatic tally_and_finish();
        $display("comparisons %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_flag(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wait_busy(input logic lvl, input int bound, output int n);
        n = 0;
        while (busy !== lvl) begin
            @(posedge clk);
            #1;
            n++;
            if (n > bound) begin
                failures++;
                $display("timeout waiting for busy at %0t", $time);
                tally_and_finish();
            end
        end
    endtask

    // Each word the host flags valid is checked against the oldest note.
    always @(posedge rx_valid) begin
        if (exp_q.size() == 0) begin
            failures++;
            $display("mismatch at %0t: got %h expected none", $time, rx);
        end else begin
            cmp_word(rx, exp_q.pop_front());
        end
    end

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        logic [31:0] nxt;
        logic [31:0] cmd;
        logic [7:0] codes[8];
        int pieces[8];
        int n;
        codes = '{8'ha0, 8'ha1, 8'ha2, 8'ha3, 8'h55, 8'ha2, 8'ha1, 8'ha3};
        pieces = '{32, 8, 16, 32, 32, 32, 16, 8};
        void'($urandom(51432));
        fork
            begin
                #1;
                sbh_host_model_i.flush();
            end
        join_none
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        cmp_flag(busy, 1'b1);
        // The link side leaves reset only on shift clock edges, so idle edges follow the release.
        sbh_host_model_i.flush();
        wait_busy(1'b0, 200, n);
        cmp_flag(n >= FIRST_N, 1'b1);
        nxt = DUMMY_WORD;
        for (int k = 0; k < 8; k++) begin
            @(posedge clk);
            results <= {$urandom, $urandom, $urandom, $urandom};
            @(posedge clk);
            #1;
            cmd = {codes[k], 24'($urandom)};
            exp_q.push_back(nxt);
            sbh_host_model_i.xfer(cmd, pieces[k], 1'b1);
            cmp_flag(busy, 1'b0);
            wait_busy(1'b1, 8, n);
            cmp_flag(n >= 1 && n <= 2, 1'b1);
            if (k == 2) begin
                sbh_host_model_i.xfer(~cmd, 32, 1'b0);
                cmp_flag(busy, 1'b1);
            end
            wait_busy(1'b0, 40, n);
            if (k != 2) begin
                cmp_word(32'(n), 32'(BUSY_N) + 32'h3);
            end
            if (codes[k][7:2] == CMD_CODE_TOP) begin
                nxt = results[codes[k][1:0]];
            end
        end
        exp_q.push_back(nxt);
        sbh_host_model_i.xfer(32'ha000_0000, 32, 1'b1);
        wait_busy(1'b1, 8, n);
        repeat (4) @(posedge clk);
        tally_and_finish();
    end
endmodule
`default_nettype wire
